// ===== include/drsr_pkg.sv
package drsr_pkg;

    // ------------------------------------------------------------
    // bank, postponement and NOP counts
    // ------------------------------------------------------------
    localparam int NUM_BANKS     = 8;
    localparam int BANK_W        = 3;
    localparam int MAX_POSTPONE  = 8;
    localparam int CREDIT_W      = 5;
    localparam int NOP_COUNT     = 2;

    // ------------------------------------------------------------
    // timing, in ns and us, and derived cycles of the 40 ns mclk
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_NS   = 40;
    localparam int RFC_AB_NS        = 130;
    localparam int RFC_PB_NS        = 60;
    localparam int RFC_AB_CYC       =
        (RFC_AB_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int RFC_PB_CYC       =
        (RFC_PB_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int SREF_RES_US      = 15;
    localparam int SREF_RES_CYC     =
        (SREF_RES_US * 1000) / MCLK_PERIOD_NS;
    localparam int CNT_W            = 16;

    typedef struct packed {
        logic       cs_n;
        logic [3:0] ca;
    } drsr_cmd_s;

    typedef struct packed {
        logic             in_self_refresh;
        logic             receivers_on;
        logic             refresh_busy;
        logic [BANK_W-1:0] bank_ptr;
    } drsr_stat_s;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SR_NOP = 2'b01,
        ST_SR     = 2'b10,
        ST_SR_EXIT = 2'b11
    } drsr_state_e;

endpackage : drsr_pkg

// ===== rtl/drsr_refresh.sv
`timescale 1ns/10ps
module drsr_refresh
    import drsr_pkg::*;
#(
    parameter int SREF_RES_CYCLES = SREF_RES_CYC
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // memory-side pins
    input  wire logic              mem_clk,
    input  wire logic              cke,
    input  wire drsr_pkg::drsr_cmd_s cmd,
    // status
    output drsr_pkg::drsr_stat_s   stat,
    output logic                   refresh_pulse,
    output logic [BANK_W-1:0]      refresh_bank,
    output logic                   refresh_all,
    output logic                   int_clk_en
);
    import drsr_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and link clock edge
    // ------------------------------------------------------------
    logic [2:0] clk_sync_q;
    logic [1:0] cke_sync_q;
    drsr_cmd_s  cmd_s1_q;
    drsr_cmd_s  cmd_s2_q;
    logic       cke_prev_q;
    logic       clk_rise;
    logic       cke_now;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_sync_q <= 3'h0;
            cke_sync_q <= 2'h0;
            cmd_s1_q   <= '1;
            cmd_s2_q   <= '1;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], mem_clk};
            cke_sync_q <= {cke_sync_q[0], cke};
            cmd_s1_q   <= cmd;
            cmd_s2_q   <= cmd_s1_q;
        end
    end

    assign clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
    assign cke_now  = cke_sync_q[1];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cke_prev_q <= 1'b0;
        end else if (clk_rise) begin
            cke_prev_q <= cke_now;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    drsr_state_e state_q;
    logic        is_ref_code;
    logic        ref_cmd;
    logic        sr_entry;
    logic        sr_exit;

    assign is_ref_code = ~cmd_s2_q.cs_n & ~cmd_s2_q.ca[0]
                         & ~cmd_s2_q.ca[1] & cmd_s2_q.ca[2];
    assign ref_cmd  = clk_rise && state_q == ST_ACTIVE
                      && cke_now && cke_prev_q && is_ref_code;
    assign sr_entry = clk_rise && state_q == ST_ACTIVE
                      && !cke_now && cke_prev_q && is_ref_code;
    assign sr_exit  = clk_rise && state_q == ST_SR && cke_now;

    // ------------------------------------------------------------
    // self-refresh state
    // ------------------------------------------------------------
    logic [CNT_W-1:0] sr_cnt_q;
    logic [1:0]       nop_cnt_q;
    logic             int_ref_done_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_ACTIVE;
            nop_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                ST_ACTIVE: begin
                    if (sr_entry) begin
                        state_q   <= ST_SR_NOP;
                        nop_cnt_q <= 2'h0;
                    end
                end
                ST_SR_NOP: begin
                    if (clk_rise) begin
                        nop_cnt_q <= nop_cnt_q + 2'h1;
                        if (nop_cnt_q == 2'(NOP_COUNT - 1)) begin
                            state_q <= ST_SR;
                        end
                    end
                end
                ST_SR: begin
                    if (sr_exit) begin
                        state_q <= ST_SR_EXIT;
                    end
                end
                ST_SR_EXIT: begin
                    if (int_ref_done_q) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                default: begin
                    state_q <= ST_ACTIVE;
                end
            endcase
        end
    end

    // internal timer runs on mclk, independent of the link clock
    logic int_ref_fire;

    assign int_ref_fire = (state_q == ST_SR || state_q == ST_SR_NOP)
                          && !int_ref_done_q
                          && sr_cnt_q == CNT_W'(RFC_AB_CYC);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sr_cnt_q       <= '0;
            int_ref_done_q <= 1'b0;
        end else if (state_q == ST_ACTIVE) begin
            sr_cnt_q       <= '0;
            int_ref_done_q <= 1'b0;
        end else begin
            if (sr_cnt_q != CNT_W'(SREF_RES_CYCLES)) begin
                sr_cnt_q <= sr_cnt_q + CNT_W'(1);
            end
            if (int_ref_fire) begin
                int_ref_done_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // refresh execution and bank counter
    // ------------------------------------------------------------
    logic [BANK_W-1:0] bank_q;
    logic [2:0]        busy_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bank_q <= '0;
        end else if (sr_exit || (ref_cmd && cmd_s2_q.ca[3])) begin
            bank_q <= '0;
        end else if (ref_cmd) begin
            bank_q <= bank_q + BANK_W'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refresh_pulse <= 1'b0;
            refresh_all   <= 1'b0;
            refresh_bank  <= '0;
        end else begin
            refresh_pulse <= ref_cmd | int_ref_fire;
            if (ref_cmd || int_ref_fire) begin
                refresh_all  <= int_ref_fire | cmd_s2_q.ca[3];
                refresh_bank <= int_ref_fire ? '0 : bank_q;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_q <= 3'h0;
        end else if (ref_cmd || int_ref_fire) begin
            busy_q <= (int_ref_fire || cmd_s2_q.ca[3])
                      ? 3'(RFC_AB_CYC) : 3'(RFC_PB_CYC);
        end else if (busy_q != 3'h0) begin
            busy_q <= busy_q - 3'h1;
        end
    end

    assign int_clk_en = (state_q == ST_ACTIVE || state_q == ST_SR_NOP
                         || state_q == ST_SR_EXIT);
    assign stat = '{in_self_refresh: (state_q != ST_ACTIVE),
                    receivers_on:    (state_q != ST_SR) | cke_now,
                    refresh_busy:    (busy_q != 3'h0),
                    bank_ptr:        bank_q};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_bank_wraps: assert property (@(posedge mclk) disable iff (rst)
        ref_cmd && !cmd_s2_q.ca[3] && bank_q == 3'h7 |=> bank_q == 3'h0)
        else $error("bank counter did not wrap");
    a_allbank_resets: assert property (@(posedge mclk) disable iff (rst)
        ref_cmd && cmd_s2_q.ca[3] |=> bank_q == 3'h0)
        else $error("all-bank refresh left bank counter");
    a_entry_decode: assert property (@(posedge mclk) disable iff (rst)
        sr_entry |=> state_q == ST_SR_NOP)
        else $error("self-refresh entry missed");
    a_internal_ref: assert property (@(posedge mclk) disable iff (rst)
        $rose(state_q == ST_SR_NOP) |-> ##[1:8] refresh_pulse && refresh_all)
        else $error("no internal refresh in residency");
    a_stays_sref: assert property (@(posedge mclk) disable iff (rst)
        state_q == ST_SR && !cke_now |=> state_q == ST_SR)
        else $error("left self-refresh with cke low");
    a_exit_clears: assert property (@(posedge mclk) disable iff (rst)
        sr_exit |=> bank_q == 3'h0)
        else $error("exit did not clear bank counter");
    a_ignore_cmds: assert property (@(posedge mclk) disable iff (rst)
        state_q == ST_SR |-> !ref_cmd)
        else $error("command taken in self-refresh");
    a_busy_time: assert property (@(posedge mclk) disable iff (rst)
        ref_cmd && cmd_s2_q.ca[3] |=> busy_q == 3'(RFC_AB_CYC))
        else $error("all-bank busy time wrong");
    a_clock_gated: assert property (@(posedge mclk) disable iff (rst)
        state_q == ST_SR |-> !int_clk_en)
        else $error("internal clock not gated");

    c_ref_ab: cover property (@(posedge mclk) ref_cmd && cmd_s2_q.ca[3]);
    c_ref_pb: cover property (@(posedge mclk) ref_cmd && !cmd_s2_q.ca[3]);
    c_sr_in:  cover property (@(posedge mclk) sr_entry);
    c_sr_out: cover property (@(posedge mclk) sr_exit);

endmodule : drsr_refresh

// ===== bench/drsr_ctrl_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// memory controller model
// ------------------------------------------------------------
module drsr_ctrl_model
    import drsr_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // memory-side pins
    output logic                   mem_clk,
    output logic                   cke,
    output drsr_pkg::drsr_cmd_s    cmd
);
    localparam drsr_cmd_s REF_AB = 5'h0c;
    localparam drsr_cmd_s REF_PB = 5'h04;
    localparam drsr_cmd_s NOP    = 5'h07;
    localparam drsr_cmd_s ACT    = 5'h02;
    localparam drsr_cmd_s DESEL  = 5'h1c;
    localparam int RMULT    = 1;
    localparam int REFI_CYC = 100 * RMULT;
    localparam int AB_UNITS = 8;
    localparam int LIM      = 8 * AB_UNITS;
    logic [2:0] ph_q;
    logic       run;
    int         credit;
    int         ivl_cnt;
    int         gap_cnt;
    int         win_cnt;
    int         win_units;
    int         units;
    int         owed;
    logic       in_sr;
    logic       acct_ok;
    logic       must_ref;
    logic       ref_seen;

    initial begin
        ph_q = 3'h0;
        run = 1'b1;
        mem_clk = 1'b0;
        cke = 1'b1;
        cmd = NOP;
        credit = 0;
        ivl_cnt = 0;
        gap_cnt = 0;
        win_cnt = 0;
        win_units = 0;
        in_sr = 1'b0;
        acct_ok = 1'b1;
    end

    // ------------------------------------------------------------
    // refresh bookkeeping, counted in single-bank refreshes
    // ------------------------------------------------------------
    assign ref_seen = ph_q == 3'h6 && !in_sr && cke === 1'b1
                      && !cmd.cs_n && cmd.ca[2:0] == 3'h4;
    assign units    = ref_seen ? (cmd.ca[3] ? AB_UNITS : 1) : 0;
    assign owed     = (ivl_cnt == REFI_CYC - 1) ? AB_UNITS : 0;
    assign must_ref = credit - AB_UNITS < -LIM;

    always @(posedge mclk) begin
        if (!in_sr) begin
            ivl_cnt <= (ivl_cnt == REFI_CYC - 1) ? 0 : ivl_cnt + 1;
            if (credit + units - owed > LIM) begin
                credit <= LIM;
            end else begin
                credit <= credit + units - owed;
            end
            gap_cnt <= (units != 0) ? 0 : gap_cnt + 1;
            win_cnt <= (win_cnt == 2 * REFI_CYC - 1) ? 0 : win_cnt + 1;
            win_units <= (win_cnt == 2 * REFI_CYC - 1) ? units
                                                       : win_units + units;
            if (credit < -LIM || gap_cnt > 9 * REFI_CYC
                || win_units > 2 * LIM) begin
                acct_ok <= 1'b0;
            end
        end
    end

    // 320 ns link clock; stands low while stopped, cmd pins inverted every mclk then, cke held
    always @(posedge mclk) begin
        if (run) begin
            ph_q <= ph_q + 3'h1;
            mem_clk <= ph_q[2];
        end else begin
            cmd <= ~cmd;
        end
    end

    // one command per link period; spacing covers refresh cycle times
    task automatic send(input drsr_cmd_s c, input logic k);
        @(posedge mclk iff ph_q == 3'h7);
        cmd <= (must_ref && k && !in_sr) ? REF_AB : c;
        cke <= k;
        @(posedge mclk iff ph_q == 3'h6);
    endtask : send

    task automatic sref_enter();
        in_sr <= 1'b1;
        send(REF_AB, 1'b0);
        send(NOP, 1'b0);
        send(NOP, 1'b0);
    endtask : sref_enter

    task automatic stop_clk(input int n);
        @(posedge mclk iff ph_q == 3'h3);
        run <= 1'b0;
        repeat (n) @(posedge mclk);
        run <= 1'b1;
    endtask : stop_clk

    task automatic sref_exit();
        send(NOP, 1'b0);
        send(NOP, 1'b0);
        repeat (5) send(NOP, 1'b1);
        in_sr <= 1'b0;
    endtask : sref_exit
endmodule : drsr_ctrl_model

// ===== bench/drsr_refresh_tb.sv
`timescale 1ns/10ps
module drsr_refresh_tb;
    import drsr_pkg::*;
    logic              mclk;
    logic              rst;
    logic              mem_clk;
    logic              cke;
    drsr_cmd_s         cmd;
    drsr_stat_s        stat;
    logic              refresh_pulse;
    logic              refresh_all;
    logic              int_clk_en;
    logic [BANK_W-1:0] refresh_bank;
    logic [BANK_W-1:0] last_bank;
    logic              last_all;
    int                failures;
    int                n_compared;
    int                n_pulse;
    int                n_busy;

    drsr_refresh #(.SREF_RES_CYCLES(16)) drsr_refresh_inst (
        .mclk(mclk), .rst(rst), .mem_clk(mem_clk), .cke(cke), .cmd(cmd),
        .stat(stat), .refresh_pulse(refresh_pulse),
        .refresh_bank(refresh_bank), .refresh_all(refresh_all),
        .int_clk_en(int_clk_en));
    drsr_ctrl_model drsr_ctrl_model_inst (
        .mclk(mclk), .mem_clk(mem_clk), .cke(cke), .cmd(cmd));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // pulse monitor and checks
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (refresh_pulse === 1'b1) begin
            n_pulse <= n_pulse + 1;
            last_all <= refresh_all;
            last_bank <= refresh_bank;
        end
        if (stat.refresh_busy === 1'b1) begin
            n_busy <= n_busy + 1;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ref_chk(input drsr_cmd_s c, input logic [7:0] n_exp,
                           input logic all_exp, input logic [2:0] bank_exp);
        int n0;
        int b0;
        int busy_exp;
        n0 = n_pulse;
        b0 = n_busy;
        busy_exp = (n_exp == 8'h0) ? 0 : (all_exp ? RFC_AB_CYC : RFC_PB_CYC);
        drsr_ctrl_model_inst.send(c, 1'b1);
        drsr_ctrl_model_inst.send(5'h07, 1'b1);
        chk(8'(n_pulse - n0), n_exp);
        chk(8'(n_busy - b0), 8'(busy_exp));
        if (n_exp != 8'h0) begin
            chk({7'h0, last_all}, {7'h0, all_exp});
            if (!all_exp) chk({5'h0, last_bank}, {5'h0, bank_exp});
        end
    endtask : ref_chk

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({4'h0, stat.in_self_refresh, stat.receivers_on,
             int_clk_en, refresh_pulse}, 8'h06);
        chk({5'h0, stat.bank_ptr}, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_codes();
        for (int b = 0; b < 9; b++) ref_chk(5'h04, 8'h1, 1'b0, 3'(b));
        ref_chk(5'h0c, 8'h1, 1'b1, 3'h0);
        chk({5'h0, stat.bank_ptr}, 8'h00);
        ref_chk(5'h04, 8'h1, 1'b0, 3'h0);
        ref_chk(5'h1c, 8'h0, 1'b0, 3'h0);
        $display("test refresh codes done");
    endtask : t_codes

    task automatic t_refused();
        int n0;
        n0 = n_pulse;
        drsr_ctrl_model_inst.send(5'h07, 1'b0);
        drsr_ctrl_model_inst.send(5'h0c, 1'b0);
        drsr_ctrl_model_inst.send(5'h07, 1'b1);
        chk({7'h0, stat.in_self_refresh}, 8'h00);
        chk(8'(n_pulse - n0), 8'h0);
        $display("test refused entry done");
    endtask : t_refused

    task automatic t_sref();
        int n0;
        int i;
        n0 = n_pulse;
        drsr_ctrl_model_inst.sref_enter();
        repeat (2) @(posedge mclk);
        chk({5'h0, stat.in_self_refresh, stat.receivers_on, int_clk_en},
            8'h04);
        chk(8'(n_pulse - n0), 8'h1);
        chk({7'h0, last_all}, 8'h01);
        drsr_ctrl_model_inst.stop_clk(40);
        chk({7'h0, stat.in_self_refresh}, 8'h01);
        drsr_ctrl_model_inst.sref_exit();
        i = 0;
        while (stat.in_self_refresh !== 1'b0 && i < 100) begin
            @(posedge mclk);
            i++;
        end
        chk({6'h0, stat.in_self_refresh, int_clk_en}, 8'h01);
        chk({5'h0, stat.bank_ptr}, 8'h00);
        ref_chk(5'h04, 8'h1, 1'b0, 3'h0);
        ref_chk(5'h02, 8'h0, 1'b0, 3'h0);
        chk({6'h0, drsr_ctrl_model_inst.acct_ok,
             drsr_ctrl_model_inst.must_ref}, 8'h02);
        $display("test self refresh done");
    endtask : t_sref

    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        #400000;
        failures++;
        conclude();
    end

    initial begin
        failures = 0;
        n_compared = 0;
        n_pulse = 0;
        n_busy = 0;
        rst = 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
        t_codes();
        t_refused();
        ref_chk(5'h04, 8'h1, 1'b0, 3'h1);
        t_sref();
        conclude();
    end
endmodule : drsr_refresh_tb
